// File: verilog/sjt_pkg.sv
// Constants, types and shared decoding for the SRAM serial test access port.
// Contract
// - All serial inputs are sampled on the rising test clock edge only.
// - Serial data out and its output enable launch on the falling edge; the updated pin word launches on the rising edge.
// - Mode select steers the state machine on rising edges; pulled high when unconnected.
// - Serial data input is pulled high so it may stay unconnected.
// - Exactly one register, chosen by the held instruction, sits between serial in and out.
// - Serial input bits enter the selected register's MSB and shift toward the LSB.
// - Serial data out presents the selected register's LSB, so bits leave LSB first.
// - Serial output driver is enabled only in shifting states, high impedance otherwise.
// - Test logic powers up in its reset state without disturbing memory operation.
// - The test clock drives only test logic; memory behaviour ignores it.
// - State machine and signalling follow boundary-scan standard 1149.1-2001.
// - Five rising edges with mode select high return test logic to reset.
// - Instruction register is three bits, loaded with identification at power-up and reset.
// - Instruction capture loads pattern 01 into the two low instruction bits.
// - Bypass is a one-bit register placed in the path under the bypass instruction.
`default_nettype none
package sjt_pkg;
  localparam int IR_LEN = 3;
  localparam int ID_LEN = 32;
  localparam int BSR_LEN_DEFAULT = 110;
  localparam int HIZ_BIT_DEFAULT = 109;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 2;

  // Instruction encodings of the three-bit instruction register.
  localparam logic [IR_LEN-1:0] INS_EXTEST = 3'h0;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 3'h1;
  localparam logic [IR_LEN-1:0] INS_SAMPLEZ = 3'h2;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 3'h4;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 3'h7;

  localparam logic [IR_LEN-1:0] IR_CAPTURE = 3'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;
  localparam logic PULL_LEVEL = 1'h1;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } sjt_tap_t;

  typedef enum logic [1:0] {SEL_BYPASS, SEL_ID, SEL_BSR} sjt_sel_t;

  // Which data register an instruction places in the serial path.
  function automatic sjt_sel_t sjt_select(input logic [IR_LEN-1:0] ins);
    sjt_sel_t sel;
    sel = SEL_BYPASS;
    case (ins)
      INS_IDCODE: sel = SEL_ID;
      INS_EXTEST, INS_SAMPLE, INS_SAMPLEZ: sel = SEL_BSR;
      default: sel = SEL_BYPASS;
    endcase
    return sel;
  endfunction
endpackage
`default_nettype wire

// File: verilog/sjt_sync.sv
// Two-flop level synchroniser for a bundle of independent single-bit levels.
`default_nettype none
module sjt_sync import sjt_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sjt_sync_st_t;

  sjt_sync_st_t cur_ff;
  sjt_sync_st_t nxt_cur;

  always_comb begin
    nxt_cur.meta = asyncIn;
    nxt_cur.stable = cur_ff.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign syncOut = cur_ff.stable;
endmodule
`default_nettype wire

// File: verilog/sjt_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`default_nettype none
module sjt_fifo import sjt_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
  } sjt_fifo_st_t;

  sjt_fifo_st_t cur_ff;
  sjt_fifo_st_t nxt_cur;
  logic push;
  logic pop;

  assign inReady = (cur_ff.count != FULL);
  assign outValid = (cur_ff.count != '0);
  assign outData = cur_ff.mem[cur_ff.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    nxt_cur = cur_ff;
    if (push) begin
      nxt_cur.mem[cur_ff.wrPtr] = inData;
      nxt_cur.wrPtr = (cur_ff.wrPtr == LAST) ? '0 : AW'(cur_ff.wrPtr + 1'b1);
    end
    if (pop) begin
      nxt_cur.rdPtr = (cur_ff.rdPtr == LAST) ? '0 : AW'(cur_ff.rdPtr + 1'b1);
    end
    if (push && !pop) begin
      nxt_cur.count = CW'(cur_ff.count + 1'b1);
    end else if (pop && !push) begin
      nxt_cur.count = CW'(cur_ff.count - 1'b1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule
`default_nettype wire

// File: verilog/sjt_tap.sv
// Serial boundary-scan test access port with a buffered pin-snapshot path from the memory clock domain.
`default_nettype none
module sjt_tap import sjt_pkg::*; #(
  parameter int BSR_LEN = BSR_LEN_DEFAULT,
  parameter int HIZ_BIT = HIZ_BIT_DEFAULT,
  // Identification value is arbitrary; bit 0 is one as the scan standard expects.
  parameter logic [ID_LEN-1:0] ID_CODE = 32'h0A5A_5001
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tmsPin,
  input wire logic tmsDriven,
  input wire logic tdiPin,
  input wire logic tdiDriven,
  output logic tdoOut,
  output logic tdoOe,
  input wire logic [BSR_LEN-1:0] sampleData,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic [BSR_LEN-1:0] testOutWord,
  output logic memOutHighZ
);
  // Memory clock domain: hands one snapshot word at a time to the test clock domain.
  typedef struct packed {
    logic reqTgl;
    logic [BSR_LEN-1:0] xferWord;
  } sjt_sys_st_t;

  // Test clock domain, rising-edge state.
  typedef struct packed {
    sjt_tap_t state;
    logic [IR_LEN-1:0] ir;
    logic [IR_LEN-1:0] irSh;
    logic bypassSh;
    logic [ID_LEN-1:0] idSh;
    logic [BSR_LEN-1:0] bsrSh;
    logic [BSR_LEN-1:0] updWord;
    logic [BSR_LEN-1:0] snapWord;
    logic reqSeen;
    logic hiZ;
  } sjt_tck_st_t;

  // Test clock domain, falling-edge state.
  typedef struct packed {
    logic tdo;
    logic oe;
  } sjt_out_st_t;

  sjt_sys_st_t sys_ff;
  sjt_sys_st_t nxt_sys;
  sjt_tck_st_t tap_ff;
  sjt_tck_st_t nxt_tap;
  sjt_out_st_t out_ff;
  sjt_out_st_t nxt_out;

  logic [BSR_LEN-1:0] fifoData;
  logic fifoValid;
  logic fifoPop;
  logic [1:0] sysSync;
  logic ackSync;
  logic reqSync;
  logic highZTck;
  logic tms;
  logic tdi;
  sjt_sel_t sel;
  logic shifting;

  // An undriven pin floats to the pull-up level.
  assign tms = tmsDriven ? tmsPin : PULL_LEVEL;
  assign tdi = tdiDriven ? tdiPin : PULL_LEVEL;

  sjt_fifo #(
    .WIDTH(BSR_LEN),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inData(sampleData),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .outData(fifoData),
    .outValid(fifoValid),
    .outReady(fifoPop)
  );

  // Acknowledge toggle and the output-disable level come back into the memory domain.
  sjt_sync #(
    .WIDTH(SYNC_STAGES)
  ) u_sys_sync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn({highZTck, tap_ff.reqSeen}),
    .syncOut(sysSync)
  );

  assign ackSync = sysSync[0];
  assign memOutHighZ = sysSync[1];

  // A new word leaves the FIFO only once the previous one has been acknowledged. While the test
  // clock stands still no acknowledge comes, so the FIFO fills and pushes back on the source.
  assign fifoPop = fifoValid && (sys_ff.reqTgl == ackSync);

  always_comb begin
    nxt_sys = sys_ff;
    if (fifoPop) begin
      nxt_sys.xferWord = fifoData;
      nxt_sys.reqTgl = !sys_ff.reqTgl;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  sjt_sync #(
    .WIDTH(1)
  ) u_tck_sync (
    .clk(tck),
    .reset_n(reset_n),
    .asyncIn(sys_ff.reqTgl),
    .syncOut(reqSync)
  );

  assign sel = sjt_select(tap_ff.ir);
  assign shifting = (tap_ff.state == TAP_SHIFT_DR) || (tap_ff.state == TAP_SHIFT_IR);
  // Taken from a flop so the synchroniser into the memory domain never sees a decode glitch.
  assign highZTck = tap_ff.hiZ;

  always_comb begin
    nxt_tap = tap_ff;
    // The handshake holds xferWord steady until the acknowledge toggle returns.
    if (reqSync != tap_ff.reqSeen) begin
      nxt_tap.snapWord = sys_ff.xferWord;
      nxt_tap.reqSeen = reqSync;
    end
    case (tap_ff.state)
      TAP_RESET: nxt_tap.state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_tap.state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_tap.state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_tap.state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nxt_tap.state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nxt_tap.state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nxt_tap.state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nxt_tap.state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: nxt_tap.state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_tap.state = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nxt_tap.state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nxt_tap.state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nxt_tap.state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nxt_tap.state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nxt_tap.state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: nxt_tap.state = tms ? TAP_SEL_DR : TAP_IDLE;
      default: nxt_tap.state = TAP_RESET;
    endcase
    case (tap_ff.state)
      TAP_RESET: begin
        nxt_tap.ir = INS_IDCODE;
      end
      TAP_CAP_IR: begin
        nxt_tap.irSh = IR_CAPTURE;
      end
      TAP_SHIFT_IR: begin
        nxt_tap.irSh = {tdi, tap_ff.irSh[IR_LEN-1:1]};
      end
      TAP_UPD_IR: begin
        nxt_tap.ir = tap_ff.irSh;
      end
      TAP_CAP_DR: begin
        case (sel)
          SEL_ID: nxt_tap.idSh = ID_CODE;
          SEL_BSR: nxt_tap.bsrSh = tap_ff.snapWord;
          default: nxt_tap.bypassSh = BYPASS_CAPTURE;
        endcase
      end
      TAP_SHIFT_DR: begin
        case (sel)
          SEL_ID: nxt_tap.idSh = {tdi, tap_ff.idSh[ID_LEN-1:1]};
          SEL_BSR: nxt_tap.bsrSh = {tdi, tap_ff.bsrSh[BSR_LEN-1:1]};
          default: nxt_tap.bypassSh = tdi;
        endcase
      end
      TAP_UPD_DR: begin
        if ((tap_ff.ir == INS_EXTEST) || (tap_ff.ir == INS_SAMPLE)) begin
          nxt_tap.updWord = tap_ff.bsrSh;
        end
      end
      default: begin
        nxt_tap.ir = tap_ff.ir;
      end
    endcase
    nxt_tap.hiZ = (nxt_tap.ir == INS_SAMPLEZ) || ((nxt_tap.ir == INS_EXTEST) && !nxt_tap.updWord[HIZ_BIT]);
  end

  // The reset is the power-on event; it needs no test clock edge to put the port in reset.
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      tap_ff <= '0;
      tap_ff.state <= TAP_RESET;
      tap_ff.ir <= INS_IDCODE;
    end else begin
      tap_ff <= nxt_tap;
    end
  end

  always_comb begin
    nxt_out.oe = shifting;
    nxt_out.tdo = 1'h0;
    if (tap_ff.state == TAP_SHIFT_IR) begin
      nxt_out.tdo = tap_ff.irSh[0];
    end else if (tap_ff.state == TAP_SHIFT_DR) begin
      case (sel)
        SEL_ID: nxt_out.tdo = tap_ff.idSh[0];
        SEL_BSR: nxt_out.tdo = tap_ff.bsrSh[0];
        default: nxt_out.tdo = tap_ff.bypassSh;
      endcase
    end
  end

  always_ff @(negedge tck or negedge reset_n) begin
    if (!reset_n) begin
      out_ff <= '0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign tdoOut = out_ff.tdo;
  assign tdoOe = out_ff.oe;
  // Only the test-side latch of updated pin data leaves here; memory traffic never sees tck.
  assign testOutWord = tap_ff.updWord;
endmodule
`default_nettype wire

// File: testbench/sjt_tap_asserts.sv
// Concurrent checks on the test access port pins, built around a reference controller walk.
`default_nettype none
module sjt_tap_asserts import sjt_pkg::*; #(
  // Arbitrary identification value; the bind hands on the real one.
  parameter logic [ID_LEN-1:0] ID_CODE = 32'h0000_0001
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tmsPin,
  input wire logic tmsDriven,
  input wire logic tdiPin,
  input wire logic tdiDriven,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic sampleReady,
  input wire logic memOutHighZ
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] NXT0 = 64'h1BDD_BBA1_4664_4311;
  localparam logic [63:0] NXT1 = 64'h2FEF_CC02_8785_5920;
  logic tmsEff;
  logic tdiEff;
  logic byp;
  logic [3:0] st;
  logic [2:0] irSh;
  logic [2:0] ir;
  assign tmsEff = tmsDriven ? tmsPin : PULL_LEVEL;
  assign tdiEff = tdiDriven ? tdiPin : PULL_LEVEL;
  assign byp = !(ir inside {INS_EXTEST, INS_IDCODE, INS_SAMPLEZ, INS_SAMPLE});
  // The walk is rebuilt from the pins alone, so a wrong design walk cannot hide itself.
  always_ff @(posedge tck or negedge reset_n) begin
    if (!reset_n) begin
      st <= 4'h0;
      irSh <= 3'h0;
      ir <= INS_IDCODE;
    end else begin
      st <= tmsEff ? NXT1[{st, 2'b00} +: 4] : NXT0[{st, 2'b00} +: 4];
      if (st == 4'hB) irSh <= {tdiEff, irSh[2:1]};
      if (st == 4'hF) ir <= irSh;
      if (st == 4'h0) ir <= INS_IDCODE;
    end
  end
  sequence capIr;
    st == 4'hA && !tmsEff;
  endsequence
  sequence fiveOnes;
    tmsEff [*5];
  endsequence
  tdo_fall_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(tdoOut) || $changed(tdoOe)) |-> !tck) else $error("serial output moved while test clock high");
  oe_shift_only_a: assert property (@(posedge tck) disable iff (!reset_n)
    tdoOe == (st == 4'h4 || st == 4'hB)) else $error("output enable outside shift states");
  tdo_idle_low_a: assert property (@(negedge tck) disable iff (!reset_n)
    !tdoOe |-> !tdoOut) else $error("serial output not low while disabled");
  tap_reset_a: assert property (@(posedge tck) disable iff (!reset_n)
    fiveOnes |=> !tdoOe [*3]) else $error("shift seen right after five high mode edges");
  ir_capture_a: assert property (@(posedge tck) disable iff (!reset_n)
    capIr ##1 !tmsEff |-> tdoOut ##1 !tdoOut) else $error("instruction capture pattern wrong");
  bypass_path_a: assert property (@(posedge tck) disable iff (!reset_n)
    st == 4'h4 && $past(st) == 4'h4 && byp |-> tdoOut == $past(tdiEff)) else $error("bypass bit wrong");
  id_first_a: assert property (@(posedge tck) disable iff (!reset_n)
    st == 4'h3 && ir == INS_IDCODE && !tmsEff |=> tdoOut == ID_CODE[0]) else $error("first id bit wrong");
  reset_state_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> !tdoOe && !tdoOut && sampleReady && !memOutHighZ) else $error("bad state after reset");
endmodule
`default_nettype wire

// File: testbench/sjt_ctrl_model.sv
// Behavioural boundary-scan controller that clocks the test port and drives its serial inputs.
`default_nettype none
module sjt_ctrl_model (
  output var logic tck,
  output var logic tms,
  output var logic tmsOn,
  output var logic tdi,
  output var logic tdiOn
);
  timeunit 1ns;
  timeprecision 100ps;
  // The bench may float the data line alone while mode select stays driven.
  logic tdiFloat = 1'b0;
  // The serial output is only watched by the bench and never loaded or driven here.
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tmsOn = 1'b1;
    tdi = 1'b1;
    tdiOn = 1'b1;
  end
  // One period; lines change just after the falling edge, and a released line shows the inverse of its last value.
  task automatic tick(input logic m, input logic d, input logic drive);
    tmsOn = drive;
    tdiOn = drive && !tdiFloat;
    tms = drive ? m : ~tms;
    tdi = tdiOn ? d : ~tdi;
    #39.3 tck = 1'b1;
    #40.7 tck = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/sjt_tap_tb.sv
// Self-checking bench for the test access port and its snapshot path.
`default_nettype none
module sjt_tap_tb import sjt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BL = 8;
  localparam logic [ID_LEN-1:0] IDV = 32'h5C3A_0001; // Arbitrary identification value.
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic sampleValid = 1'b0;
  logic [BL-1:0] sampleData = 8'h00;
  logic tck, tmsPin, tmsDriven, tdiPin, tdiDriven, tdoOut, tdoOe, sampleReady, memOutHighZ;
  logic [BL-1:0] testOutWord;
  logic [BL-1:0] lastWord;
  logic [BL-1:0] upd = 8'h00;
  logic [63:0] rnd;
  logic expQ[$];
  int mismatches = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  sjt_ctrl_model ctl (.tck(tck), .tms(tmsPin), .tmsOn(tmsDriven), .tdi(tdiPin), .tdiOn(tdiDriven));
  sjt_tap #(.BSR_LEN(BL), .HIZ_BIT(BL - 1), .ID_CODE(IDV)) uut (.clk(clk), .reset_n(reset_n), .tck(tck),
    .tmsPin(tmsPin), .tmsDriven(tmsDriven), .tdiPin(tdiPin), .tdiDriven(tdiDriven), .tdoOut(tdoOut),
    .tdoOe(tdoOe), .sampleData(sampleData), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .testOutWord(testOutWord), .memOutHighZ(memOutHighZ));
  task automatic chk(input string n, input logic [BL-1:0] e, input logic [BL-1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Every bit the controller takes while the driver is on must have been announced by the scan that caused it.
  always @(posedge tck) begin
    if (tdoOe === 1'b1) begin
      if (expQ.size() == 0) chk("tdoOe", 1'b0, tdoOe);
      else chk("tdo", expQ.pop_front(), tdoOut);
    end
  end
  task automatic scan(input bit ir, input int n, input logic [63:0] din, input logic [63:0] dout);
    for (int i = 0; i < n; i++) expQ.push_back(dout[i]);
    ctl.tick(1'b1, 1'b0, 1'b1);
    if (ir) ctl.tick(1'b1, 1'b0, 1'b1);
    ctl.tick(1'b0, 1'b0, 1'b1);
    ctl.tick(1'b0, 1'b0, 1'b1);
    for (int i = 0; i < n; i++) ctl.tick(i == n - 1, din[i], 1'b1);
    ctl.tick(1'b1, 1'b0, 1'b1);
    ctl.tick(1'b0, 1'b0, 1'b1);
    chk("tdo bits left", 8'h00, 8'(expQ.size()));
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sampleValid <= 1'b1;
      sampleData <= BL'($urandom);
      @(negedge clk);
      if (sampleReady !== 1'b1) break;
      lastWord = sampleData;
    end
    @(posedge clk);
    sampleValid <= 1'b0;
    @(negedge clk);
  endtask
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(61605));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    ctl.tick(1'b0, 1'b0, 1'b1);
    scan(0, 32, 64'h0, 64'(IDV));
    for (int c = 0; c < 8; c++) begin
      rnd = 64'($urandom);
      push(1);
      scan(1, 3, 64'(c), 64'h1);
      if (c == 1) scan(0, 32, rnd, 64'(IDV));
      else if (c inside {0, 2, 4}) scan(0, BL, rnd, 64'(lastWord));
      else if (c != 7) scan(0, 4, rnd, {rnd[2:0], 1'b0});
      else begin
        // A floating data line must read as ones through the pull-up.
        ctl.tdiFloat = 1'b1;
        scan(0, 4, rnd, 64'hE);
        ctl.tdiFloat = 1'b0;
      end
      if (c == 0 || c == 4) upd = rnd[BL-1:0];
      chk("testOutWord", upd, testOutWord);
      chk("memOutHighZ", c == 2 || (c == 0 && !upd[BL-1]), memOutHighZ);
    end
    ctl.tick(1'b1, 1'b0, 1'b1);
    ctl.tick(1'b0, 1'b0, 1'b1);
    repeat (5) ctl.tick(1'b0, 1'b0, 1'b0);
    ctl.tick(1'b0, 1'b0, 1'b1);
    scan(0, 32, 64'($urandom), 64'(IDV));
    // With the test clock still, nothing crosses, so the queue has to fill and refuse.
    push(12);
    chk("sampleReady full", 1'b0, sampleReady);
    repeat (40) ctl.tick(1'b0, 1'b0, 1'b1);
    @(negedge clk);
    chk("sampleReady drained", 1'b1, sampleReady);
    scan(1, 3, 64'(INS_SAMPLE), 64'h1);
    scan(0, BL, 64'h0, 64'(lastWord));
    final_report();
  end
endmodule
bind sjt_tap sjt_tap_asserts #(.ID_CODE(ID_CODE)) chk_i (.clk(clk), .reset_n(reset_n), .tck(tck),
  .tmsPin(tmsPin), .tmsDriven(tmsDriven), .tdiPin(tdiPin), .tdiDriven(tdiDriven), .tdoOut(tdoOut),
  .tdoOe(tdoOe), .sampleReady(sampleReady), .memOutHighZ(memOutHighZ));
`default_nettype wire
